// [src/dedc_sequencer.sv]
// dram edc cycle sequencer: word read, word write and byte read-modify-write
// How it works
// - input latches hold while hold enable low
// - hold enable falls after read data settles
// - read recomputes six check bits and compares
// - error flag low on any bit error
// - multi-bit flag low on uncorrectable words
// - result latch captures corrected word
// - lane drives enabled before result capture
// - bus-side latches capture at cycle end
// - every cycle ends with cycle-done pulse
// - writes strobe board, row, column like reads
// - writes output six generated check bits
// - result latch never drives during writes
// - write strobe timing 180 delay, 130 low
// - byte write is word read then write
// - byte write holds wait until cycle-done ends
// - merge new byte, regenerate check bits
// - cycle-done is one 70 ns low pulse (66 ns rounded up to 7 cycles)
// - error status held until software clears
`timescale 1ns/1ps
`include "dedc_defines.svh"
module dedc_sequencer
    import dedc_pkg::*;
#(
    parameter int AW = 18,
    parameter int RW = 8
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // request from processor or system bus master
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_from_bus,
    input wire logic req_byte_hi_en,
    input wire logic [AW-1:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic req_wait_r,
    output logic cycle_done_n_r,
    output logic [15:0] bus_rdata_r,
    // local data bus from the result latch
    output logic [15:0] local_data_r,
    output logic local_drive_r,
    // error status
    input wire logic err_clear,
    output logic fault_n_r,
    output logic multi_bit_fault_n_r,
    output logic err_held_r,
    output logic [AW-1:0] err_addr_r,
    output logic [5:0] err_syndrome_r,
    output logic [2:0] err_status_r,
    // edc latch controls
    output logic input_latch_hold_n_r,
    output logic result_latch_capture_n_r,
    output logic low_lane_drive_n_r,
    output logic high_lane_drive_n_r,
    // memory board
    output logic board_pick_r,
    output logic row_strobe_n_r,
    output logic col_strobe_n_r,
    output logic col_sel_r,
    output logic [RW-1:0] mem_addr_r,
    output logic write_strobe_n_r,
    output logic [15:0] mem_wdata_r,
    output logic mem_wdrive_r,
    output logic [5:0] check_bit_out_r,
    input wire logic [15:0] mem_rdata,
    input wire logic [5:0] mem_rcheck
);

    function automatic dedc_chk_t col_of(input int i);
        logic [95:0] h;
        h = `DEDC_COLS;
        return h[i*6 +: 6];
    endfunction

    function automatic dedc_chk_t gen_check(input dedc_word_t d);
        dedc_chk_t c;
        c = '0;
        for (int i = 0; i < 16; i++)
        begin
            if (d[i])
                c = c ^ col_of(i);
        end
        return c;
    endfunction

    function automatic dedc_word_t fix_word(input dedc_word_t d, input dedc_chk_t s);
        dedc_word_t f;
        f = d;
        for (int i = 0; i < 16; i++)
        begin
            if (col_of(i) == s)
                f[i] = ~f[i];
        end
        return f;
    endfunction

    // memory pins come from another board: two flops before use
    dedc_word_t rd_s1_r, rd_s2_r;
    dedc_chk_t ck_s1_r, ck_s2_r;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rd_s1_r <= '0;
            rd_s2_r <= '0;
            ck_s1_r <= '0;
            ck_s2_r <= '0;
        end
        else
        begin
            rd_s1_r <= mem_rdata;
            rd_s2_r <= rd_s1_r;
            ck_s1_r <= mem_rcheck;
            ck_s2_r <= ck_s1_r;
        end
    end

    dedc_state_e st_r, st_nxt;
    logic [5:0] tcnt_r, tcnt_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    dedc_word_t wdata_r, wdata_nxt, in_data_r, in_data_nxt;
    dedc_chk_t in_check_r, in_check_nxt;
    logic byte_r, byte_nxt, hi_r, hi_nxt, bus_r, bus_nxt;
    logic wait_nxt, done_n_nxt, ldrv_nxt, fault_nxt, multi_nxt, held_nxt;
    logic hold_nxt, capt_nxt, lo_nxt, hi_drv_nxt;
    logic pick_nxt, ras_nxt, cas_nxt, csel_nxt, we_nxt, wdrv_nxt;
    dedc_word_t brd_nxt, ldat_nxt, mwd_nxt;
    logic [AW-1:0] eaddr_nxt;
    dedc_chk_t esyn_nxt, cbo_nxt;
    logic [2:0] estat_nxt;
    logic [RW-1:0] maddr_nxt;
    dedc_chk_t syn_w;
    dedc_word_t corr_w, merge_w;
    logic multi_w;

    // edc datapath on the held input latch
    always_comb
    begin
        syn_w = gen_check(in_data_r) ^ in_check_r;
        corr_w = fix_word(in_data_r, syn_w);
        multi_w = (syn_w != `DEDC_SYN_OK) && ($countones(syn_w) != 1)
            && (corr_w == in_data_r);
        merge_w = hi_r ? {wdata_r[15:8], corr_w[7:0]} : {corr_w[15:8], wdata_r[7:0]};
    end

    always_comb
    begin
        st_nxt = st_r;
        tcnt_nxt = tcnt_r + `DEDC_CNT_ONE;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        byte_nxt = byte_r;
        hi_nxt = hi_r;
        bus_nxt = bus_r;
        // transparent while hold enable high, frozen while low
        in_data_nxt = input_latch_hold_n_r ? rd_s2_r : in_data_r;
        in_check_nxt = input_latch_hold_n_r ? ck_s2_r : in_check_r;
        wait_nxt = req_wait_r;
        done_n_nxt = cycle_done_n_r;
        brd_nxt = bus_rdata_r;
        ldat_nxt = local_data_r;
        ldrv_nxt = local_drive_r;
        fault_nxt = fault_n_r;
        multi_nxt = multi_bit_fault_n_r;
        held_nxt = err_held_r && !err_clear;
        eaddr_nxt = err_addr_r;
        esyn_nxt = err_syndrome_r;
        estat_nxt = err_status_r;
        hold_nxt = input_latch_hold_n_r;
        capt_nxt = result_latch_capture_n_r;
        lo_nxt = low_lane_drive_n_r;
        hi_drv_nxt = high_lane_drive_n_r;
        pick_nxt = board_pick_r;
        ras_nxt = row_strobe_n_r;
        cas_nxt = col_strobe_n_r;
        csel_nxt = col_sel_r;
        maddr_nxt = mem_addr_r;
        we_nxt = write_strobe_n_r;
        mwd_nxt = mem_wdata_r;
        wdrv_nxt = mem_wdrive_r;
        cbo_nxt = check_bit_out_r;
        // row/column sequence shared by read and write parts
        if (st_r == S_READ || st_r == S_WRITE)
        begin
            if (tcnt_r == 6'(`DEDC_CAS_CYC - 1))
            begin
                csel_nxt = 1'b1;
                maddr_nxt = addr_r[2*RW:RW+1];
            end
            if (tcnt_r == 6'(`DEDC_CAS_CYC))
                cas_nxt = 1'b0;
        end
        unique case (st_r)
            S_IDLE:
            begin
                tcnt_nxt = `DEDC_CNT_ZERO;
                if (req_valid)
                begin
                    addr_nxt = req_addr;
                    wdata_nxt = req_wdata;
                    bus_nxt = req_from_bus;
                    hi_nxt = req_addr[0];
                    byte_nxt = req_write && !(req_byte_hi_en && !req_addr[0]);
                    wait_nxt = byte_nxt;
                    pick_nxt = 1'b1;
                    ras_nxt = 1'b0;
                    maddr_nxt = req_addr[RW:1];
                    ldrv_nxt = 1'b0;
                    if (req_write && !byte_nxt)
                    begin
                        mwd_nxt = req_wdata;
                        cbo_nxt = gen_check(req_wdata);
                        wdrv_nxt = 1'b1;
                        st_nxt = S_WRITE;
                    end
                    else
                        st_nxt = S_READ;
                end
            end
            S_READ:
            begin
                // freeze the latch only after access time past column strobe
                if (tcnt_r == 6'(`DEDC_LATCH_AT - 1))
                begin
                    hold_nxt = 1'b0;
                    st_nxt = S_CHECK;
                end
            end
            S_CHECK:
            begin
                fault_nxt = (syn_w == `DEDC_SYN_OK);
                multi_nxt = !multi_w;
                // a new error while the clear arrives still gets captured
                if (syn_w != `DEDC_SYN_OK && (!err_held_r || err_clear))
                begin
                    held_nxt = 1'b1;
                    eaddr_nxt = addr_r;
                    esyn_nxt = syn_w;
                    estat_nxt = {bus_r, byte_r, multi_w};
                end
                if (byte_r)
                begin
                    mwd_nxt = merge_w;
                    cbo_nxt = gen_check(merge_w);
                    wdrv_nxt = 1'b1;
                    tcnt_nxt = `DEDC_CNT_ZERO;
                    st_nxt = S_WRITE;
                end
                else
                begin
                    lo_nxt = 1'b0;
                    hi_drv_nxt = 1'b0;
                    st_nxt = S_CAPT;
                end
            end
            S_CAPT:
            begin
                capt_nxt = 1'b0;
                ldat_nxt = corr_w;
                ldrv_nxt = 1'b1;
                if (bus_r)
                    brd_nxt = corr_w;
                done_n_nxt = 1'b0;
                tcnt_nxt = `DEDC_CNT_ZERO;
                st_nxt = S_DONE;
            end
            S_WRITE:
            begin
                ldrv_nxt = 1'b0;
                if (tcnt_r == 6'(`DEDC_WE_DLY_CYC - 1))
                    we_nxt = 1'b0;
                if (tcnt_r == 6'(`DEDC_WE_DLY_CYC + `DEDC_WE_LOW_CYC - 1))
                begin
                    we_nxt = 1'b1;
                    done_n_nxt = 1'b0;
                    tcnt_nxt = `DEDC_CNT_ZERO;
                    st_nxt = S_DONE;
                end
            end
            S_DONE:
            begin
                if (tcnt_r == 6'(`DEDC_DONE_CYC - 1))
                begin
                    done_n_nxt = 1'b1;
                    wait_nxt = 1'b0;
                    hold_nxt = 1'b1;
                    capt_nxt = 1'b1;
                    lo_nxt = 1'b1;
                    hi_drv_nxt = 1'b1;
                    pick_nxt = 1'b0;
                    ras_nxt = 1'b1;
                    cas_nxt = 1'b1;
                    csel_nxt = 1'b0;
                    wdrv_nxt = 1'b0;
                    ldrv_nxt = 1'b0;
                    st_nxt = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            st_r <= S_IDLE;
            tcnt_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
            byte_r <= 1'b0;
            hi_r <= 1'b0;
            bus_r <= 1'b0;
            in_data_r <= '0;
            in_check_r <= '0;
            req_wait_r <= 1'b0;
            cycle_done_n_r <= 1'b1;
            bus_rdata_r <= '0;
            local_data_r <= '0;
            local_drive_r <= 1'b0;
            fault_n_r <= 1'b1;
            multi_bit_fault_n_r <= 1'b1;
            err_held_r <= 1'b0;
            err_addr_r <= '0;
            err_syndrome_r <= '0;
            err_status_r <= '0;
            input_latch_hold_n_r <= 1'b1;
            result_latch_capture_n_r <= 1'b1;
            low_lane_drive_n_r <= 1'b1;
            high_lane_drive_n_r <= 1'b1;
            board_pick_r <= 1'b0;
            row_strobe_n_r <= 1'b1;
            col_strobe_n_r <= 1'b1;
            col_sel_r <= 1'b0;
            mem_addr_r <= '0;
            write_strobe_n_r <= 1'b1;
            mem_wdata_r <= '0;
            mem_wdrive_r <= 1'b0;
            check_bit_out_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            tcnt_r <= tcnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            byte_r <= byte_nxt;
            hi_r <= hi_nxt;
            bus_r <= bus_nxt;
            in_data_r <= in_data_nxt;
            in_check_r <= in_check_nxt;
            req_wait_r <= wait_nxt;
            cycle_done_n_r <= done_n_nxt;
            bus_rdata_r <= brd_nxt;
            local_data_r <= ldat_nxt;
            local_drive_r <= ldrv_nxt;
            fault_n_r <= fault_nxt;
            multi_bit_fault_n_r <= multi_nxt;
            err_held_r <= held_nxt;
            err_addr_r <= eaddr_nxt;
            err_syndrome_r <= esyn_nxt;
            err_status_r <= estat_nxt;
            input_latch_hold_n_r <= hold_nxt;
            result_latch_capture_n_r <= capt_nxt;
            low_lane_drive_n_r <= lo_nxt;
            high_lane_drive_n_r <= hi_drv_nxt;
            board_pick_r <= pick_nxt;
            row_strobe_n_r <= ras_nxt;
            col_strobe_n_r <= cas_nxt;
            col_sel_r <= csel_nxt;
            mem_addr_r <= maddr_nxt;
            write_strobe_n_r <= we_nxt;
            mem_wdata_r <= mwd_nxt;
            mem_wdrive_r <= wdrv_nxt;
            check_bit_out_r <= cbo_nxt;
        end
    end

    // helper: length of the current write strobe low phase
    logic [5:0] we_cnt_r;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || write_strobe_n_r)
            we_cnt_r <= '0;
        else
            we_cnt_r <= we_cnt_r + `DEDC_CNT_ONE;
    end

    localparam int LATCH_AT = `DEDC_LATCH_AT;
    localparam int WE_AT = `DEDC_WE_DLY_CYC;
    localparam int WE_LOW = `DEDC_WE_LOW_CYC;
    localparam int WE_MIN = `DEDC_WE_MIN_CYC;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence done_pulse;
        !cycle_done_n_r [*7] ##1 cycle_done_n_r;
    endsequence
    sequence drive_then_capture;
        (!low_lane_drive_n_r && !high_lane_drive_n_r) ##1 $fell(result_latch_capture_n_r);
    endsequence

    hold_keeps_a: assert property (
        !input_latch_hold_n_r |=> $stable(in_data_r) && $stable(in_check_r))
        else $error("input latch changed while held");
    settle_time_a: assert property (
        $fell(input_latch_hold_n_r) |-> tcnt_r == 6'(LATCH_AT))
        else $error("input latch froze before data settled");
    fault_flag_a: assert property (
        st_r == S_CHECK |=> fault_n_r == ($past(syn_w) == `DEDC_SYN_OK))
        else $error("error flag disagrees with syndrome");
    multi_flag_a: assert property (!multi_bit_fault_n_r |-> !fault_n_r)
        else $error("multi-bit flag without error flag");
    drive_order_a: assert property (
        $fell(input_latch_hold_n_r) && !byte_r |-> ##1 drive_then_capture)
        else $error("lane drives not ahead of result capture");
    capture_fix_a: assert property (
        $fell(result_latch_capture_n_r) |-> local_data_r == $past(corr_w))
        else $error("result latch lacks corrected word");
    bus_capture_a: assert property (
        $fell(cycle_done_n_r) && bus_r && !byte_r && input_latch_hold_n_r == 1'b0
        && st_r == S_DONE && $past(st_r) == S_CAPT |-> bus_rdata_r == $past(corr_w))
        else $error("bus-side latch missed read data");
    done_width_a: assert property ($fell(cycle_done_n_r) |-> done_pulse)
        else $error("cycle done pulse wrong length");
    we_start_a: assert property ($fell(write_strobe_n_r) |-> tcnt_r == 6'(WE_AT))
        else $error("write strobe fell at wrong time");
    we_width_a: assert property (
        $rose(write_strobe_n_r) |-> $past(we_cnt_r) == 6'(WE_LOW - 1)
        && $past(we_cnt_r) >= 6'(WE_MIN - 1))
        else $error("write strobe low time wrong");
    write_quiet_a: assert property (
        st_r == S_WRITE |-> !local_drive_r && result_latch_capture_n_r)
        else $error("result latch drives during write");
    write_check_a: assert property (
        !write_strobe_n_r |-> check_bit_out_r == gen_check(mem_wdata_r))
        else $error("check bits do not match write word");
    byte_wait_a: assert property (
        st_r == S_IDLE && req_valid && req_write && req_addr[0] |=> req_wait_r)
        else $error("byte write without wait state");
    status_hold_a: assert property (
        err_held_r && !err_clear |=> err_held_r && $stable(err_addr_r)
        && $stable(err_syndrome_r))
        else $error("error status changed while held");

endmodule // dedc_sequencer

// [common/dedc_defines.svh]
// timing counts and check-matrix constants for the edc cycle sequencer
`ifndef DEDC_DEFINES_SVH
`define DEDC_DEFINES_SVH

`define DEDC_CLK_NS 10
`define DEDC_CAS_NS 75
`define DEDC_ACC_NS 135
`define DEDC_WE_DLY_NS 180
`define DEDC_WE_LOW_NS 130
`define DEDC_WE_MIN_NS 55
`define DEDC_DONE_NS 66

// least times round up to whole cycles
`define DEDC_CAS_CYC ((`DEDC_CAS_NS + `DEDC_CLK_NS - 1) / `DEDC_CLK_NS)
`define DEDC_ACC_CYC ((`DEDC_ACC_NS + `DEDC_CLK_NS - 1) / `DEDC_CLK_NS)
`define DEDC_LATCH_AT (`DEDC_CAS_CYC + `DEDC_ACC_CYC)
`define DEDC_WE_DLY_CYC ((`DEDC_WE_DLY_NS + `DEDC_CLK_NS - 1) / `DEDC_CLK_NS)
`define DEDC_WE_LOW_CYC ((`DEDC_WE_LOW_NS + `DEDC_CLK_NS - 1) / `DEDC_CLK_NS)
`define DEDC_WE_MIN_CYC ((`DEDC_WE_MIN_NS + `DEDC_CLK_NS - 1) / `DEDC_CLK_NS)
`define DEDC_DONE_CYC ((`DEDC_DONE_NS + `DEDC_CLK_NS - 1) / `DEDC_CLK_NS)

// check-matrix column per data bit, bit i at [6i+5:6i], all weight three
`define DEDC_COLS {6'h2c, 6'h2a, 6'h29, 6'h26, 6'h25, 6'h23, 6'h1c, 6'h1a, \
    6'h19, 6'h16, 6'h15, 6'h13, 6'h0e, 6'h0d, 6'h0b, 6'h07}
`define DEDC_SYN_OK 6'h00
`define DEDC_CNT_ZERO 6'h00
`define DEDC_CNT_ONE 6'h01

`endif

// [common/dedc_pkg.sv]
// types shared by the edc cycle sequencer
package dedc_pkg;
    typedef enum logic [2:0] {S_IDLE, S_READ, S_CHECK, S_CAPT, S_WRITE, S_DONE} dedc_state_e;
    typedef logic [15:0] dedc_word_t;
    typedef logic [5:0] dedc_chk_t;
endpackage

// [bench/dedc_mem_model.sv]
// behavioural memory board: word store with check bits, read data with injected flips
`timescale 1ns/1ps
module dedc_mem_model
    import dedc_pkg::*;
#(
    parameter int RW = 8
)(
    // clock
    input wire logic sys_clk,
    // strobes and address from the sequencer
    input wire logic board_pick_r,
    input wire logic row_strobe_n_r,
    input wire logic col_strobe_n_r,
    input wire logic write_strobe_n_r,
    input wire logic [RW-1:0] mem_addr_r,
    // write side
    input wire logic mem_wdrive_r,
    input wire logic [15:0] mem_wdata_r,
    input wire logic [5:0] check_bit_out_r,
    // bench-commanded data bit flips on read
    input wire logic [15:0] flip,
    // read side
    output logic [15:0] mem_rdata,
    output logic [5:0] mem_rcheck
);
    logic [21:0] store [logic [2*RW-1:0]];
    logic [RW-1:0] row_a, col_a;
    logic row_p = 1'h1, col_p = 1'h1, we_p = 1'h1;
    int since = 0;
    initial {mem_rcheck, mem_rdata} = 22'h0;
    always @(posedge sys_clk)
    begin
        if (row_p && !row_strobe_n_r)
            row_a = mem_addr_r;
        if (col_p && !col_strobe_n_r)
        begin
            col_a = mem_addr_r;
            since = 0;
        end
        else if (!col_strobe_n_r)
            since++;
        if (we_p && !write_strobe_n_r && board_pick_r && mem_wdrive_r)
            store[{col_a, row_a}] = {check_bit_out_r, mem_wdata_r};
        // access time runs from the column strobe; outside it the pins wander
        if (board_pick_r && !col_strobe_n_r && write_strobe_n_r && since >= 9)
            {mem_rcheck, mem_rdata} <= (store.exists({col_a, row_a}) ?
                store[{col_a, row_a}] : 22'h0) ^ {6'h00, flip};
        else
            {mem_rcheck, mem_rdata} <= ~{mem_rcheck, mem_rdata};
        row_p = row_strobe_n_r;
        col_p = col_strobe_n_r;
        we_p = write_strobe_n_r;
    end
endmodule // dedc_mem_model

// [bench/test_dram_edc_cycle_sequencer.sv]
// self-checking bench for the edc cycle sequencer
`timescale 1ns/1ps
`include "dedc_defines.svh"
module test_dram_edc_cycle_sequencer
    import dedc_pkg::*;
;
    typedef struct {
        logic wr, bus, hi;
        logic [17:0] addr;
        logic [15:0] wdata, flip, exp;
        logic ef, em;
    } dedc_row_s;
    logic sys_clk = 1'h0, rst_b = 1'h0, err_clear = 1'h0;
    logic req_valid = 1'h0, req_write = 1'h0, req_from_bus = 1'h0, req_byte_hi_en = 1'h0;
    logic [17:0] req_addr = 18'h0;
    logic [15:0] req_wdata = 16'h0, flip = 16'h0;
    logic req_wait_r, cycle_done_n_r, local_drive_r, fault_n_r, multi_bit_fault_n_r, err_held_r;
    logic input_latch_hold_n_r, result_latch_capture_n_r, low_lane_drive_n_r, high_lane_drive_n_r;
    logic board_pick_r, row_strobe_n_r, col_strobe_n_r, col_sel_r, write_strobe_n_r, mem_wdrive_r;
    logic [15:0] bus_rdata_r, local_data_r, mem_wdata_r, mem_rdata;
    logic [17:0] err_addr_r;
    logic [5:0] err_syndrome_r, check_bit_out_r, mem_rcheck;
    logic [2:0] err_status_r;
    logic [7:0] mem_addr_r;
    int num_errors = 0, cmp_count = 0;
    // word writes, byte writes on both lanes, reads from both masters, one and two flipped bits
    dedc_row_s rows [9] = '{
        '{1'h1, 1'h0, 1'h1, 18'h00020, 16'h1234, 16'h0, 16'h1234, 1'h1, 1'h1},
        '{1'h0, 1'h0, 1'h1, 18'h00020, 16'h0, 16'h0, 16'h1234, 1'h1, 1'h1},
        '{1'h1, 1'h1, 1'h1, 18'h02ace, 16'ha5c3, 16'h0, 16'ha5c3, 1'h1, 1'h1},
        '{1'h0, 1'h1, 1'h1, 18'h02ace, 16'h0, 16'h0, 16'ha5c3, 1'h1, 1'h1},
        '{1'h1, 1'h0, 1'h1, 18'h00021, 16'hff00, 16'h0, 16'hff34, 1'h1, 1'h1},
        '{1'h1, 1'h1, 1'h0, 18'h00020, 16'h0077, 16'h0, 16'hff77, 1'h1, 1'h1},
        '{1'h0, 1'h1, 1'h1, 18'h00020, 16'h0, 16'h0, 16'hff77, 1'h1, 1'h1},
        '{1'h0, 1'h0, 1'h1, 18'h00020, 16'h0, 16'h0001, 16'hff77, 1'h0, 1'h1},
        '{1'h0, 1'h1, 1'h1, 18'h02ace, 16'h0, 16'h0003, 16'h0, 1'h0, 1'h0}};

    dedc_sequencer i_dut (.sys_clk, .rst_b, .req_valid, .req_write, .req_from_bus,
        .req_byte_hi_en, .req_addr, .req_wdata, .req_wait_r, .cycle_done_n_r, .bus_rdata_r,
        .local_data_r, .local_drive_r, .err_clear, .fault_n_r, .multi_bit_fault_n_r,
        .err_held_r, .err_addr_r, .err_syndrome_r, .err_status_r, .input_latch_hold_n_r,
        .result_latch_capture_n_r, .low_lane_drive_n_r, .high_lane_drive_n_r, .board_pick_r,
        .row_strobe_n_r, .col_strobe_n_r, .col_sel_r, .mem_addr_r, .write_strobe_n_r,
        .mem_wdata_r, .mem_wdrive_r, .check_bit_out_r, .mem_rdata, .mem_rcheck);
    dedc_mem_model i_mem (.sys_clk, .board_pick_r, .row_strobe_n_r, .col_strobe_n_r,
        .write_strobe_n_r, .mem_addr_r, .mem_wdrive_r, .mem_wdata_r, .check_bit_out_r,
        .flip, .mem_rdata, .mem_rcheck);

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [5:0] gen_chk(input logic [15:0] w);
        logic [95:0] cols;
        logic [5:0] c;
        cols = `DEDC_COLS;
        c = 6'h00;
        for (int i = 0; i < 16; i++)
            if (w[i])
                c = c ^ cols[6*i +: 6];
        return c;
    endfunction

    task automatic cmp_v(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_n(input string nm, input int e, input int g);
        cmp_count++;
        if (g != e)
        begin
            num_errors++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic run_row(input dedc_row_s r);
        int n, dfall, dlow, wfall, wlow;
        logic hold, wt, drv, pick, cas, capd, lanes, byt;
        logic [15:0] cap, wd;
        logic [5:0] cb;
        n = 0;
        dfall = -1;
        dlow = 0;
        wfall = -1;
        wlow = 0;
        {hold, wt, drv, pick, cas, capd, lanes} = 7'h0;
        byt = r.wr && !(r.hi && !r.addr[0]);
        req_valid = 1'h1;
        req_write = r.wr;
        req_from_bus = r.bus;
        req_byte_hi_en = r.hi;
        req_addr = r.addr;
        req_wdata = r.wdata;
        flip = r.flip;
        @(negedge sys_clk);
        req_valid = 1'h0;
        while (!(dfall >= 0 && cycle_done_n_r === 1'h1) && n < 120)
        begin
            if (cycle_done_n_r === 1'h0)
            begin
                dfall = (dfall < 0) ? n : dfall;
                dlow++;
            end
            if (write_strobe_n_r === 1'h0)
            begin
                if (wfall < 0)
                begin
                    wfall = n;
                    wd = mem_wdata_r;
                    cb = check_bit_out_r;
                end
                wlow++;
            end
            hold |= (input_latch_hold_n_r === 1'h0);
            wt |= (req_wait_r === 1'h1);
            drv |= (local_drive_r === 1'h1);
            pick |= (board_pick_r === 1'h1) && (row_strobe_n_r === 1'h0);
            cas |= (col_strobe_n_r === 1'h0) && (col_sel_r === 1'h1);
            if (!capd && result_latch_capture_n_r === 1'h0)
            begin
                capd = 1'h1;
                cap = local_data_r;
                lanes = (low_lane_drive_n_r === 1'h0) && (high_lane_drive_n_r === 1'h0);
            end
            @(negedge sys_clk);
            n++;
        end
        cmp_n("cycle end width", 7, dlow);
        cmp_v("pick and strobes", 2'h3, {pick, cas});
        cmp_v("wait state", byt, wt);
        if (r.wr)
        begin
            cmp_n("write strobe low", 13, wlow);
            cmp_n("write strobe delay", byt ? 41 : 18, wfall);
            cmp_v("write word", r.exp, wd);
            cmp_v("check bits", gen_chk(r.exp), cb);
            cmp_v("result drive", 1'h0, drv);
            cmp_v("read part", byt, hold);
        end
        else
        begin
            cmp_v("input hold", 1'h1, hold);
            cmp_v("lanes first", 1'h1, lanes);
            cmp_v("read drive", 1'h1, drv);
            cmp_v("fault flag", r.ef, fault_n_r);
            cmp_v("multi flag", r.em, multi_bit_fault_n_r);
            if (r.em)
                cmp_v("result word", r.exp, cap);
            if (r.em && r.bus)
                cmp_v("bus word", r.exp, bus_rdata_r);
        end
    endtask

    initial
    begin
        repeat (12) @(negedge sys_clk);
        rst_b = 1'h1;
        cmp_v("reset outputs", 5'h16, {cycle_done_n_r, board_pick_r, write_strobe_n_r,
            fault_n_r, err_held_r});
        foreach (rows[i])
        begin
            run_row(rows[i]);
            if (i == 7)
            begin
                cmp_v("error held", 1'h1, err_held_r);
                cmp_v("error syndrome", 6'h07, err_syndrome_r);
                cmp_v("error status", 3'h0, err_status_r);
            end
        end
        // the later double error must not overwrite the held status
        cmp_v("error address", 18'h00020, err_addr_r);
        err_clear = 1'h1;
        @(negedge sys_clk);
        err_clear = 1'h0;
        @(negedge sys_clk);
        cmp_v("error cleared", 1'h0, err_held_r);
        close_out();
    end

    initial
    begin
        #200000;
        num_errors++;
        close_out();
    end
endmodule // test_dram_edc_cycle_sequencer
